// file: logic/skew_cal_params.svh
/*
  Offsets, reset values and widths for the output skew and calibration
  control block.
  Assumes inclusion by its bare name from files under logic/.
*/
`ifndef SKEW_CAL_PARAMS_SVH
`define SKEW_CAL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_OUT3_PHASE 8'h8E
`define OFS_OUT4_PHASE 8'h8F
`define OFS_OUT5_PHASE 8'h90

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_OUT3_PHASE 8'h00
`define RST_OUT4_PHASE 8'h00
`define RST_OUT5_PHASE 8'h00
`define RST_UNMAPPED   8'h00

// ----------------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------------
`define CFG_W 3

`endif

// file: logic/skew_cal_pkg.sv
/*
  Types shared by the output skew and calibration control block.
  Assumes the params header is on the include path.
*/
`include "skew_cal_params.svh"

package skew_cal_pkg;

  typedef logic signed [7:0]          offset_t;
  typedef logic [7:0]                 reg_addr_t;
  typedef logic [`CFG_W-1:0]          cfg_t;

  // Gray codes along wait -> calibrate -> run.
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_CAL  = 2'h1,
    ST_RUN  = 2'h3
  } cal_state_t;

endpackage : skew_cal_pkg

// file: logic/output_skew_and_cal_control.sv
/*
  Phase offset registers for outputs three to five and output gating
  around internal calibration.
  Assumes the serial host port delivers decoded register strobes on
  CLK_SYS, and the calibration engine pulses its start and done events
  on CLK_SYS as well.
*/
`timescale 1ns/1ps
`default_nettype none
`include "skew_cal_params.svh"

// Functional notes
// R1: Each skew field is an 8-bit signed offset in high-speed divider clocks.
// R2: The fifth output's offset is applied only while the config setting is 0.
// R3: The third output's offset register resets to zero.
// R4: Always-on 0, squelch 0: outputs stay off until the first calibration ends.
// R5: Always-on 0, squelch 1: outputs stay off until the first good calibration.
// R6: Always-on 1: outputs stay on at all times outside reset, calibration included.
// R7: Skew between outputs is kept across calibration only with squelch set.
// R8: Software should calibrate after changing any listed setting.
// R9: A low reset input returns all internal logic to a known state.
// R10: Reset loads every control register with its default.
// R11: All outputs are held off while reset is asserted.
// R12: The host must program the device after reset before any output runs; the code waits only for a calibration end
//      (a good one with squelch set), or for nothing with always-on set.
// R13: Each offset field moves only its own output, without disturbing others.
// R14: Loss of lock stands through calibration and clears on a good finish.
module output_skew_and_cal_control (
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_B,
  input  wire skew_cal_pkg::reg_addr_t REG_ADDR,
  input  wire logic [7:0]              REG_WDATA,
  input  wire logic                    REG_WE,
  output logic [7:0]                   REG_RDATA,
  input  wire skew_cal_pkg::cfg_t      CLOCK_CONFIGURATION_SETTING,
  input  wire logic                    OUTPUTS_ALWAYS_ON,
  input  wire logic                    SQUELCH_DURING_CALIBRATION,
  input  wire logic                    CAL_START,
  input  wire logic                    CAL_DONE,
  input  wire logic                    CAL_OK,
  output logic                         LOSS_OF_LOCK,
  output logic [4:0]                   OUTPUT_CLOCK_EN,
  output logic                         SKEW_PRESERVED,
  output skew_cal_pkg::offset_t        PHASE_OFFSET3,
  output skew_cal_pkg::offset_t        PHASE_OFFSET4,
  output skew_cal_pkg::offset_t        PHASE_OFFSET5,
  output logic [2:0]                   PHASE_UPDATE
);
  import skew_cal_pkg::*;

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  offset_t    phase_r [3];
  logic [7:0] rdata_r;
  wire  [7:0] ofs [3] = '{`OFS_OUT3_PHASE, `OFS_OUT4_PHASE,
                          `OFS_OUT5_PHASE};
  wire  [7:0] rst_val [3] = '{`RST_OUT3_PHASE, `RST_OUT4_PHASE,
                              `RST_OUT5_PHASE};
  wire  [2:0] hit;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      assign hit[g] = (REG_ADDR == ofs[g]);
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          phase_r[g] <= offset_t'(rst_val[g]);  // [R3] [R10]
        end else if (REG_WE && hit[g]) begin
          phase_r[g] <= offset_t'(REG_WDATA);   // [R1] [R13]
        end
      end
    end
  endgenerate

  wire [7:0] rdata_nxt = hit[0] ? phase_r[0] :
                         hit[1] ? phase_r[1] :
                         hit[2] ? phase_r[2] : `RST_UNMAPPED;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) rdata_r <= `RST_UNMAPPED;
    else        rdata_r <= rdata_nxt;
  end
  assign REG_RDATA = rdata_r;

  // --------------------------------------------------------------------
  // Applied offsets
  // --------------------------------------------------------------------
  // Each applied offset follows only its own field, so rewriting one
  // output never pulses the update strobe of another.
  offset_t    applied_r [3];
  offset_t    applied_nxt [3];
  logic [2:0] upd_r;

  assign applied_nxt[0] = phase_r[0];
  assign applied_nxt[1] = phase_r[1];
  assign applied_nxt[2] = (CLOCK_CONFIGURATION_SETTING == '0) ?
                          phase_r[2] : offset_t'(8'h00);  // [R2]

  generate
    for (g = 0; g < 3; g++) begin : g_apply
      always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
          applied_r[g] <= offset_t'(8'h00);
          upd_r[g]     <= 1'b0;
        end else begin
          applied_r[g] <= applied_nxt[g];                  // [R13]
          upd_r[g]     <= (applied_r[g] != applied_nxt[g]); // [R13]
        end
      end
    end
  endgenerate

  assign PHASE_OFFSET3 = applied_r[0];
  assign PHASE_OFFSET4 = applied_r[1];
  assign PHASE_OFFSET5 = applied_r[2];
  assign PHASE_UPDATE  = upd_r;

  // --------------------------------------------------------------------
  // Calibration tracking
  // --------------------------------------------------------------------
  cal_state_t state_r;
  cal_state_t state_nxt;
  logic       first_cal_r;
  logic       first_lock_r;
  logic       lol_r;
  logic [4:0] en_r;
  wire        cal_end  = (state_r == ST_CAL) && CAL_DONE;
  wire        cal_good = cal_end && CAL_OK;
  wire        in_cal   = (state_r == ST_CAL);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_WAIT: if (CAL_START) state_nxt = ST_CAL;
      ST_CAL:  if (CAL_DONE)  state_nxt = CAL_OK ? ST_RUN : ST_WAIT;
      ST_RUN:  if (CAL_START) state_nxt = ST_CAL;
      default: state_nxt = ST_WAIT;
    endcase
  end

  // Unless always-on is set, squelch drops the outputs during every calibration
  // so they restart aligned; without it they run free and alignment is not kept.
  wire en_nxt = OUTPUTS_ALWAYS_ON ? 1'b1 :                      // [R6]
                SQUELCH_DURING_CALIBRATION ?
                  (first_lock_r && !in_cal) :                   // [R5] [R7]
                  first_cal_r;                                  // [R4]

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      state_r      <= ST_WAIT;  // [R9]
      first_cal_r  <= 1'b0;     // [R12]
      first_lock_r <= 1'b0;
      lol_r        <= 1'b1;
      en_r         <= 5'h00;    // [R11]
    end else begin
      state_r      <= state_nxt;
      first_cal_r  <= first_cal_r | cal_end;
      first_lock_r <= first_lock_r | cal_good;
      lol_r        <= (state_nxt == ST_RUN) ? 1'b0 : 1'b1;  // [R14]
      en_r         <= {5{en_nxt}};
    end
  end

  assign LOSS_OF_LOCK    = lol_r;
  assign OUTPUT_CLOCK_EN = en_r;
  assign SKEW_PRESERVED  = SQUELCH_DURING_CALIBRATION;  // [R7]

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  sequence s_cal_run;
    CAL_START && (state_r != ST_CAL) ##1 in_cal;
  endsequence

  sequence s_good_end;
    in_cal && CAL_DONE && CAL_OK;
  endsequence

  reset_off_a: assert property (@(posedge CLK_SYS) // [R11]
    !RST_B |=> (OUTPUT_CLOCK_EN == 5'h00) && LOSS_OF_LOCK)
    else $error("outputs not off after reset");

  reset_val_a: assert property (@(posedge CLK_SYS) // [R3]
    !RST_B |=> (phase_r[0] == 8'h00) && (REG_RDATA == 8'h00))
    else $error("offset three not cleared by reset");

  always_on_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    OUTPUTS_ALWAYS_ON |=> (OUTPUT_CLOCK_EN == 5'h1F)) // [R6]
    else $error("outputs off while always-on set");

  no_cal_off_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !first_cal_r && !OUTPUTS_ALWAYS_ON |=> OUTPUT_CLOCK_EN == 5'h00) // [R4]
    else $error("outputs on before first calibration");

  squelch_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    s_cal_run ##0 (SQUELCH_DURING_CALIBRATION && !OUTPUTS_ALWAYS_ON)
    |=> OUTPUT_CLOCK_EN == 5'h00) // [R5]
    else $error("outputs not squelched during calibration");

  lol_cal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    s_cal_run |-> LOSS_OF_LOCK) // [R14]
    else $error("lock indication low during calibration");

  lol_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    s_good_end |=> !LOSS_OF_LOCK && first_lock_r) // [R14]
    else $error("lock not shown after good calibration");

  out5_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    CLOCK_CONFIGURATION_SETTING != '0 |=> PHASE_OFFSET5 == 8'h00) // [R2]
    else $error("offset five applied with nonzero config");

  write_iso_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    REG_WE && hit[0] |=> ##1 PHASE_OFFSET3 == $past(REG_WDATA, 2)
      && !upd_r[1]) // [R13]
    else $error("offset three write not isolated");

  // A failed calibration must leave loss of lock asserted.
  lol_fail_a: assert property (@(posedge CLK_SYS) // [R14]
    disable iff (!RST_B) in_cal && CAL_DONE && !CAL_OK |=> LOSS_OF_LOCK)
    else $error("lock shown after failed calibration");

  out5_apply_a: assert property (@(posedge CLK_SYS) // [R2]
    disable iff (!RST_B) CLOCK_CONFIGURATION_SETTING == '0
    |=> PHASE_OFFSET5 == $past(phase_r[2]))
    else $error("offset five not applied with zero config");

endmodule : output_skew_and_cal_control
`default_nettype wire

// file: test/tb_output_skew_and_cal_control.sv
/*
  Self-checking bench for the output skew and calibration control block.
  Assumes the block's package and params header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "skew_cal_params.svh"
module tb_output_skew_and_cal_control;
  import skew_cal_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_b = 1'b0;
  reg_addr_t         addr = 8'h00;
  logic [7:0]        wdata = 8'h00;
  logic              we = 1'b0;
  logic [7:0]        rdata;
  cfg_t              cfg = 3'h0;
  logic              on = 1'b0;
  logic              sq = 1'b0;
  logic              start = 1'b0;
  logic              done = 1'b0;
  logic              ok = 1'b0;
  logic              loss_of_lock;
  logic [4:0]        en;
  logic              keep;
  offset_t           ph3;
  offset_t           ph4;
  offset_t           ph5;
  logic [2:0]        upd;
  int                num_errors = 0;
  int                comparisons = 0;
  int                cycles = 0;
  output_skew_and_cal_control u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we), .REG_RDATA(rdata),
    .CLOCK_CONFIGURATION_SETTING(cfg), .OUTPUTS_ALWAYS_ON(on),
    .SQUELCH_DURING_CALIBRATION(sq), .CAL_START(start), .CAL_DONE(done),
    .CAL_OK(ok), .LOSS_OF_LOCK(loss_of_lock), .OUTPUT_CLOCK_EN(en),
    .SKEW_PRESERVED(keep), .PHASE_OFFSET3(ph3), .PHASE_OFFSET4(ph4),
    .PHASE_OFFSET5(ph5), .PHASE_UPDATE(upd));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    tick(1);
    chk(rdata, exp);
  endtask : rd
  // Checks the enables midway through a calibration, then ends it.
  task automatic cal(input logic good, input logic [4:0] mid);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    chk(8'(loss_of_lock), 8'h01);
    chk(8'(en), 8'(mid));
    ok = good;
    done = 1'b1;
    tick(1);
    done = 1'b0;
    tick(3);
  endtask : cal
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic do_reset();
    rst_b = 1'b0;
    tick(10);
    chk(8'(en), 8'h00);
    rst_b = 1'b1;
    tick(1);
    chk(ph3, 8'h00);
    rd(`OFS_OUT3_PHASE, `RST_OUT3_PHASE);
    rd(`OFS_OUT4_PHASE, `RST_OUT4_PHASE);
    rd(`OFS_OUT5_PHASE, `RST_OUT5_PHASE);
  endtask : do_reset
  task automatic offsets();
    wr(`OFS_OUT4_PHASE, 8'h80);
    tick(1);
    chk(ph4, 8'h80);
    chk(8'(upd), 8'h02);
    chk(ph3, 8'h00);
    tick(1);
    chk(8'(upd), 8'h00);
    wr(`OFS_OUT3_PHASE, 8'hC3);
    tick(1);
    chk(ph3, 8'hC3);
    chk(8'(upd), 8'h01);
    chk(ph4, 8'h80);
    wr(8'h91, 8'h55);
    rd(8'h91, `RST_UNMAPPED);
    cfg = 3'h1;
    wr(`OFS_OUT5_PHASE, 8'h7F);
    tick(2);
    chk(ph5, 8'h00);
    rd(`OFS_OUT5_PHASE, 8'h7F);
    cfg = 3'h0;
    tick(3);
    chk(ph5, 8'h7F);
  endtask : offsets
  task automatic squelch_off();
    chk(8'(en), 8'h00);
    chk(8'(keep), 8'h00);
    cal(1'b1, 5'h00);
    chk(8'(en), 8'h1F);
    chk(8'(loss_of_lock), 8'h00);
  endtask : squelch_off
  task automatic squelch_on();
    sq = 1'b1;
    do_reset();
    chk(8'(keep), 8'h01);
    cal(1'b0, 5'h00);
    chk(8'(en), 8'h00);
    chk(8'(loss_of_lock), 8'h01);
    cal(1'b1, 5'h00);
    chk(8'(en), 8'h1F);
    cal(1'b1, 5'h00);
  endtask : squelch_on
  task automatic always_on();
    on = 1'b1;
    wr(`OFS_OUT3_PHASE, 8'hA5);
    do_reset();
    tick(3);
    chk(8'(en), 8'h1F);
    cal(1'b0, 5'h1F);
    chk(8'(en), 8'h1F);
  endtask : always_on
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // A hang in any scenario is cut short well past the expected run length.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    do_reset();
    offsets();
    squelch_off();
    squelch_on();
    always_on();
    conclude();
  end
endmodule : tb_output_skew_and_cal_control
`default_nettype wire
